// [fpc_far_model.sv]
`timescale 1ns/1ps
module fpc_far_model
    import fpc_pkg::*;
(
    input  wire logic             i_clock,
    input  wire logic             i_stall,
    output logic      [VEC_W-1:0] o_tx_cg,
    output logic                  o_tx_valid,
    input  wire logic             i_tx_ready,
    input  wire logic [VEC_W-1:0] i_rx_cg,
    input  wire logic             i_rx_valid,
    output logic                  o_rx_ready
);
    logic [VEC_W-1:0] got[$];

    initial begin
        o_tx_cg = '0;
        o_tx_valid = 1'b0;
        o_rx_ready = 1'b1;
    end

    task automatic send(input logic [VEC_W-1:0] w, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        o_tx_cg <= w;
        o_tx_valid <= 1'b1;
        while (!ok && n < 20) begin
            #1;
            ok = (i_tx_ready === 1'b1);
            @(posedge i_clock);
            n++;
        end
    endtask

    // released bus shows the inverse so a stale word never matches
    task automatic release_tx();
        o_tx_valid <= 1'b0;
        o_tx_cg <= ~o_tx_cg;
    endtask

    always @(posedge i_clock) begin
        o_rx_ready <= !i_stall;
        if (i_rx_valid === 1'b1 && o_rx_ready) begin
            got.push_back(i_rx_cg);
        end
    end
endmodule

// [fpc_monitor.sv]
`timescale 1ns/1ps
module fpc_monitor
    import fpc_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic             I_CLOCK,
    input wire logic             I_ARST_N,
    input wire logic             O_TX_READY,
    input wire logic [VEC_W-1:0] O_TX_LINE,
    input wire logic [VEC_W-1:0] O_RX_CG,
    input wire logic             O_RX_VALID,
    input wire logic             I_RX_READY,
    input wire logic             I_LOOPBACK,
    input wire fpc_test_t        I_TEST_SEL,
    input wire logic             O_LINK_OK,
    input wire logic             O_LINK_NOTICE,
    input wire logic             O_RX_OVERFLOW,
    input wire logic [6:0]       O_SPACING
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);

    // substituted or idle lanes all sit inside the disparity window
    function automatic logic lanes_ok(input logic [VEC_W-1:0] v);
        lanes_ok = 1'b1;
        for (int i = 0; i < LANES; i++) begin
            if ($countones(v[i*CG_W +: CG_W]) < ONES_MIN ||
                $countones(v[i*CG_W +: CG_W]) > ONES_MAX) begin
                lanes_ok = 1'b0;
            end
        end
    endfunction

    AST_NOTICE_ON_CHANGE: assert property ($changed(O_LINK_OK) |-> O_LINK_NOTICE)
        else $error("link status changed without notice");
    AST_NOTICE_ONLY_CHANGE: assert property (O_LINK_NOTICE |-> $changed(O_LINK_OK))
        else $error("notice without link change");
    AST_SPACING_NONZERO: assert property (O_SPACING != 7'h00)
        else $error("spacing generator reached zero");
    AST_SPACING_MOVES: assert property ($past(I_ARST_N) |-> O_SPACING != $past(O_SPACING))
        else $error("spacing generator stalled");
    AST_RX_LANES_VALID: assert property (O_RX_VALID |-> lanes_ok(O_RX_CG))
        else $error("invalid code-group passed upward");
    AST_RX_HOLD: assert property (O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_CG))
        else $error("receive word changed while stalled");
    AST_RX_ONLY_LINKED: assert property ($rose(O_RX_VALID) |-> $past(O_LINK_OK) || $past(O_LINK_OK, 2))
        else $error("receive valid without link");
    AST_LOOP_RESYNC: assert property ($changed(I_LOOPBACK) |-> ##[1:4] !O_LINK_OK)
        else $error("loopback change kept link up");
    AST_TEST_HIGH: assert property (I_TEST_SEL == TEST_HIGH && $past(I_TEST_SEL) == TEST_HIGH &&
        $past(I_TEST_SEL, 2) == TEST_HIGH |-> O_TX_LINE == {LANES{PAT_HIGH}})
        else $error("high test pattern wrong");
    AST_OVERFLOW_FULL: assert property (O_RX_OVERFLOW |-> $past(O_RX_VALID) && !$past(I_RX_READY))
        else $error("overflow without full buffer");
    AST_TX_READY_NORMAL: assert property (I_TEST_SEL == TEST_OFF && $past(I_TEST_SEL) == TEST_OFF
        |-> O_TX_READY)
        else $error("transmit refused in normal mode");

    COV_LINK_UP: cover property ($rose(O_LINK_OK));
    COV_OVERFLOW: cover property (O_RX_OVERFLOW);
    COV_TX_FULL: cover property (!O_TX_READY);
endmodule

bind fpc_top fpc_monitor #(.BUF_DEPTH(BUF_DEPTH)) u_mon (.I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N),
    .O_TX_READY(O_TX_READY), .O_TX_LINE(O_TX_LINE), .O_RX_CG(O_RX_CG), .O_RX_VALID(O_RX_VALID),
    .I_RX_READY(I_RX_READY), .I_LOOPBACK(I_LOOPBACK), .I_TEST_SEL(I_TEST_SEL),
    .O_LINK_OK(O_LINK_OK), .O_LINK_NOTICE(O_LINK_NOTICE), .O_RX_OVERFLOW(O_RX_OVERFLOW),
    .O_SPACING(O_SPACING));

// [fpc_pkg.sv]
package fpc_pkg;

    // lane and vector geometry
    localparam int LANES = 4;
    localparam int CG_W  = 10;
    localparam int VEC_W = LANES * CG_W;

    // special code-groups, first transmitted bit in bit 0
    localparam logic [9:0] COMMA_NEG = 10'h17c;
    localparam logic [9:0] COMMA_POS = 10'h283;
    localparam logic [9:0] ERROR_NEG = 10'h05e;
    localparam logic [9:0] ERROR_POS = 10'h3a1;

    // jitter test patterns
    localparam logic [9:0] PAT_HIGH = 10'h155;
    localparam logic [9:0] PAT_LOW  = 10'h01f;

    // disparity window of a valid code-group
    localparam int ONES_MIN = 4;
    localparam int ONES_MAX = 6;

    // lane synchronisation counts
    localparam logic [2:0] SYNC_COMMAS   = 3'h4;
    localparam logic [2:0] LOSS_INVALIDS = 3'h4;

    // alignment-spacing generator
    localparam logic [6:0] PRNG_SEED = 7'h7f;
    localparam int         POLY_X3   = 0;
    localparam int         POLY_X6   = 1;

    // round-trip latency budget, one bit time is 100 ps at 10 Gb/s
    localparam int LATENCY_BT      = 2048;
    localparam int BIT_TIME_PS     = 100;
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int LATENCY_MAX_CYC = (LATENCY_BT * BIT_TIME_PS) / CLK_PERIOD_PS;

    // transmit source selection
    typedef enum logic [1:0] {
        TEST_OFF   = 2'b00,
        TEST_HIGH  = 2'b01,
        TEST_LOW   = 2'b10,
        TEST_MIXED = 2'b11
    } fpc_test_t;

    // lane sync states, gray along lost -> acquire -> synced
    typedef enum logic [1:0] {
        ST_LOST = 2'b00,
        ST_ACQ  = 2'b01,
        ST_SYNC = 2'b11
    } fpc_sync_t;

endpackage

// [fpc_top.sv]
// What this block does
// (R1) Transmit plus receive latency through the block stays within 2048 bit times.
// (R2) A seven-bit generator on x^7+x^3+1 or x^7+x^6+1 sets alignment-character spacing.
// (R3) Each lane recognises the comma in both running-disparity forms.
// (R4) An invalid received code-group is replaced by the error code-group before going up; here only groups with under 4 or over 6 ones count as invalid.
// (R5) Clock-rate differences may be absorbed by adding or dropping idle words.
// (R6) A link status with only the values OK and FAIL is kept.
// (R7) The negotiation link notice pulses on each change of link status and never otherwise.
// (R8) Loopback is provided for the attachment and host-side extender paths.
// (R9) Clock and data are taken from each lane while the line is within 3.125 GBd +-100 ppm.
// (R10) Jitter test patterns may be sent, chosen by a select input.
// (R11) Energy-saving idle, if offered, adds its own states and machines with their timing.
// (R12) In loopback all four transmit lanes feed the receiver and the line input is ignored.
// (R13) Four 10-bit code-groups, one per lane, cross each way every 312.5 MHz cycle.
// (R14) Entering or leaving loopback restarts lane sync and withholds valid until regained; words already in the receive buffer still go up valid.
`timescale 1ns/1ps

module fpc_buf #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 2
) (
    input  wire logic             i_clock,
    input  wire logic             i_arst_n,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_reg;
    logic [PW-1:0]    wr_next;
    logic [PW-1:0]    rd_reg;
    logic [PW-1:0]    rd_next;
    logic [CW-1:0]    cnt_reg;
    logic [CW-1:0]    cnt_next;
    logic             push;
    logic             pop;

    assign o_ready = (cnt_reg != CW'(DEPTH));
    assign o_valid = (cnt_reg != '0);
    assign o_data  = mem_reg[rd_reg];

    always_comb begin
        push     = i_valid && o_ready;
        pop      = o_valid && i_ready;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
        end
        if (pop) begin
            rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + CW'(1);
        end else if (pop && !push) begin
            cnt_next = cnt_reg - CW'(1);
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
            if (push) begin
                mem_reg[wr_reg] <= i_data;
            end
        end
    end
endmodule

module fpc_lane (
    input  wire logic       i_clock,
    input  wire logic       i_arst_n,
    input  wire logic [9:0] i_cg,
    input  wire logic       i_restart,
    output logic      [9:0] o_cg,
    output logic            o_comma,
    output logic            o_sync
);
    import fpc_pkg::*;

    fpc_sync_t   st_reg;
    fpc_sync_t   st_next;
    logic [9:0]  prev_reg;
    logic [3:0]  off_reg;
    logic [3:0]  off_next;
    logic [2:0]  cnt_reg;
    logic [2:0]  cnt_next;
    logic [9:0]  cg_reg;
    logic [9:0]  cg_next;
    logic        comma_reg;
    logic        comma_next;
    logic [19:0] window;
    logic [9:0]  aligned;
    logic        hit;
    logic [3:0]  hit_off;
    logic        bad;
    logic        is_k;

    // (R3) both disparities
    function automatic logic comma_of(input logic [9:0] cg);
        return (cg == COMMA_NEG) || (cg == COMMA_POS);
    endfunction

    assign o_cg    = cg_reg;
    assign o_comma = comma_reg;
    assign o_sync  = (st_reg == ST_SYNC);

    always_comb begin
        window  = {i_cg, prev_reg};
        hit     = 1'b0;
        hit_off = 4'h0;
        // lowest offset wins so the earliest comma in the window locks
        for (int k = 9; k >= 0; k--) begin
            if (comma_of(window[k +: 10])) begin
                hit     = 1'b1;
                hit_off = 4'(k);
            end
        end
        aligned = window[off_reg +: 10];
        // disparity check only, not a full table decode
        bad     = ($countones(aligned) < ONES_MIN) || ($countones(aligned) > ONES_MAX);
        is_k    = comma_of(aligned);
        st_next  = st_reg;
        off_next = off_reg;
        cnt_next = cnt_reg;
        unique case (st_reg)
            ST_LOST: begin
                if (hit) begin
                    off_next = hit_off;
                    cnt_next = 3'h1;
                    st_next  = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (bad) begin
                    st_next = ST_LOST;
                end else if (is_k) begin
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == SYNC_COMMAS - 3'h1) begin
                        cnt_next = 3'h0;
                        st_next  = ST_SYNC;
                    end
                end
            end
            ST_SYNC: begin
                if (!bad) begin
                    cnt_next = 3'h0;
                end else if (cnt_reg == LOSS_INVALIDS - 3'h1) begin
                    st_next = ST_LOST;
                end else begin
                    cnt_next = cnt_reg + 3'h1;
                end
            end
            default: begin
                st_next = ST_LOST;
            end
        endcase
        // (R14) resync on restart
        if (i_restart) begin
            st_next  = ST_LOST;
            cnt_next = 3'h0;
        end
        // (R4) error code-group swap
        cg_next    = bad ? ERROR_NEG : aligned;
        comma_next = is_k;
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg    <= ST_LOST;
            prev_reg  <= '0;
            off_reg   <= '0;
            cnt_reg   <= '0;
            cg_reg    <= ERROR_NEG;
            comma_reg <= 1'b0;
        end else begin
            st_reg    <= st_next;
            prev_reg  <= i_cg;
            off_reg   <= off_next;
            cnt_reg   <= cnt_next;
            cg_reg    <= cg_next;
            comma_reg <= comma_next;
        end
    end
endmodule

module fpc_top #(
    parameter int POLY_SEL = fpc_pkg::POLY_X6,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic                     I_CLOCK,
    input  wire logic                     I_ARST_N,
    input  wire logic [fpc_pkg::VEC_W-1:0] I_TX_CG,
    input  wire logic                     I_TX_VALID,
    output logic                          O_TX_READY,
    output logic      [fpc_pkg::VEC_W-1:0] O_TX_LINE,
    input  wire logic [fpc_pkg::VEC_W-1:0] I_RX_LINE,
    output logic      [fpc_pkg::VEC_W-1:0] O_RX_CG,
    output logic                          O_RX_VALID,
    input  wire logic                     I_RX_READY,
    input  wire logic                     I_LOOPBACK,
    input  wire fpc_pkg::fpc_test_t       I_TEST_SEL,
    output logic                          O_LINK_OK,
    output logic                          O_LINK_NOTICE,
    output logic                          O_RX_OVERFLOW,
    output logic      [6:0]               O_SPACING
);
    import fpc_pkg::*;

    logic [VEC_W-1:0] tx_reg;
    logic [VEC_W-1:0] tx_next;
    logic             rd_reg;
    logic             rd_next;
    logic [6:0]       prng_reg;
    logic [6:0]       prng_next;
    logic             lb_reg;
    logic             link_reg;
    logic             link_next;
    logic             notice_reg;
    logic             notice_next;
    logic             ovf_reg;
    logic             ovf_next;
    logic [VEC_W-1:0] txb_data;
    logic             txb_valid;
    logic             txb_take;
    logic [VEC_W-1:0] rx_src;
    logic [VEC_W-1:0] lane_cg;
    logic [LANES-1:0] lane_comma;
    logic [LANES-1:0] lane_sync;
    logic             restart;
    logic             idle_word;
    logic             rxb_ready;
    logic             rxb_push;
    logic [9:0]       comma_cg;

    // (R8) loopback path selected here
    // (R12) all lanes together, line ignored
    assign rx_src  = I_LOOPBACK ? tx_reg : I_RX_LINE;
    assign restart = (I_LOOPBACK != lb_reg);
    // (R13) 40-bit vector each way
    assign O_TX_LINE = tx_reg;
    assign O_SPACING = prng_reg;
    assign O_LINK_OK = link_reg;
    assign O_LINK_NOTICE = notice_reg;
    assign O_RX_OVERFLOW = ovf_reg;
    // test patterns hold off user data, so the transmit buffer fills
    assign txb_take = (I_TEST_SEL == TEST_OFF);
    assign comma_cg = rd_reg ? COMMA_POS : COMMA_NEG;

    fpc_buf #(.WIDTH(VEC_W), .DEPTH(BUF_DEPTH)) u_txb (
        .i_clock (I_CLOCK),
        .i_arst_n(I_ARST_N),
        .i_data  (I_TX_CG),
        .i_valid (I_TX_VALID),
        .o_ready (O_TX_READY),
        .o_data  (txb_data),
        .o_valid (txb_valid),
        .i_ready (txb_take)
    );

    // (R9) each lane word is taken as recovered at the code-group rate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        fpc_lane u_lane (
            .i_clock  (I_CLOCK),
            .i_arst_n (I_ARST_N),
            .i_cg     (rx_src[g*CG_W +: CG_W]),
            .i_restart(restart),
            .o_cg     (lane_cg[g*CG_W +: CG_W]),
            .o_comma  (lane_comma[g]),
            .o_sync   (lane_sync[g])
        );
    end

    // (R11) no energy-saving idle states offered
    assign idle_word = &lane_comma;
    // (R14) nothing is pushed while link_reg is low; words already buffered stay valid
    // (R5) a full buffer drops idle words without overflow; a data word is lost and flags overflow
    assign rxb_push = link_reg && !(idle_word && !rxb_ready);

    fpc_buf #(.WIDTH(VEC_W), .DEPTH(BUF_DEPTH)) u_rxb (
        .i_clock (I_CLOCK),
        .i_arst_n(I_ARST_N),
        .i_data  (lane_cg),
        .i_valid (rxb_push),
        .o_ready (rxb_ready),
        .o_data  (O_RX_CG),
        .o_valid (O_RX_VALID),
        .i_ready (I_RX_READY)
    );

    always_comb begin
        rd_next = rd_reg;
        unique case (I_TEST_SEL)
            // (R10) selectable jitter patterns
            TEST_HIGH: tx_next = {LANES{PAT_HIGH}};
            TEST_LOW:  tx_next = {LANES{PAT_LOW}};
            TEST_MIXED: begin
                tx_next = {LANES{comma_cg}};
                rd_next = !rd_reg;
            end
            default: begin
                if (txb_valid) begin
                    tx_next = txb_data;
                end else begin
                    // (R5) idle inserted when no word is waiting
                    tx_next = {LANES{comma_cg}};
                    rd_next = !rd_reg;
                end
            end
        endcase
        // (R2) seven-bit generator, polynomial by parameter
        if (POLY_SEL == POLY_X3) begin
            prng_next = {prng_reg[5:0], prng_reg[6] ^ prng_reg[2]};
        end else begin
            prng_next = {prng_reg[5:0], prng_reg[6] ^ prng_reg[5]};
        end
        // (R6) OK only with all lanes synced
        link_next   = &lane_sync;
        // (R7) pulse on change only
        notice_next = (link_next != link_reg);
        ovf_next    = link_reg && !idle_word && !rxb_ready;
    end

    // (R1) two transmit stages and three receive stages (prev_reg, cg_reg, buffer) keep latency far under the budget
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tx_reg     <= '0;
            rd_reg     <= 1'b0;
            prng_reg   <= PRNG_SEED;
            lb_reg     <= 1'b0;
            link_reg   <= 1'b0;
            notice_reg <= 1'b0;
            ovf_reg    <= 1'b0;
        end else begin
            tx_reg     <= tx_next;
            rd_reg     <= rd_next;
            prng_reg   <= prng_next;
            lb_reg     <= I_LOOPBACK;
            link_reg   <= link_next;
            notice_reg <= notice_next;
            ovf_reg    <= ovf_next;
        end
    end
endmodule

// [test_four_lane_8b10b_pcs_core.sv]
`timescale 1ns/1ps
module test_four_lane_8b10b_pcs_core;
    import fpc_pkg::*;
    logic             clock = 1'b0;
    logic             arst_n = 1'b0;
    logic [VEC_W-1:0] tx_cg, tx_line, rx_cg;
    logic [VEC_W-1:0] rx_line = '0;
    logic [VEC_W-1:0] line_word = '0;
    logic [19:0]      junk = '0;
    logic             tx_valid, tx_ready, rx_valid, rx_ready, link_ok, link_notice, rx_ovf;
    logic             loopback = 1'b0;
    logic             stall = 1'b0;
    fpc_test_t        test_sel = TEST_OFF;
    logic [6:0]       spacing;
    int               fail_count = 0;
    int               samples_checked = 0;
    logic [VEC_W-1:0] w[3] = '{{4{10'h2aa}}, {4{10'h0cc}}, {2{10'h2aa, 10'h0cc}}};

    always #2 clock = ~clock;

    // a looped-back receiver must ignore this changing line
    always @(posedge clock) begin
        junk <= junk + 20'h1;
        rx_line <= loopback ? {junk, ~junk} : line_word;
    end

    fpc_top dut (.I_CLOCK(clock), .I_ARST_N(arst_n), .I_TX_CG(tx_cg), .I_TX_VALID(tx_valid),
        .O_TX_READY(tx_ready), .O_TX_LINE(tx_line), .I_RX_LINE(rx_line), .O_RX_CG(rx_cg),
        .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .I_LOOPBACK(loopback),
        .I_TEST_SEL(test_sel), .O_LINK_OK(link_ok), .O_LINK_NOTICE(link_notice),
        .O_RX_OVERFLOW(rx_ovf), .O_SPACING(spacing));

    fpc_far_model far (.i_clock(clock), .i_stall(stall), .o_tx_cg(tx_cg), .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready), .i_rx_cg(rx_cg), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready));

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %0t %s", $time, m);
            fail_count++;
        end
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            cmp(1'b0, 1'b1, "wait ran out");
            give_verdict();
        end
    endtask

    // a refused word counts as a mismatch and ends the run
    task automatic put(input logic [VEC_W-1:0] v);
        bit ok;
        far.send(v, ok);
        bound(ok ? 0 : 1, 1);
    endtask

    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (16) @(posedge clock);
        #1;
        cmp(link_ok, 1'b0, "reset link");
        cmp(spacing, PRNG_SEED, "reset seed");
        @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
    endtask

    task automatic wait_link(input logic v);
        int n = 0;
        while (link_ok !== v && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        bound(n, 300);
        cmp(link_notice, 1'b1, "notice at change");
    endtask

    task automatic t_comma();
        for (int f = 0; f < 2; f++) begin
            line_word <= {LANES{f ? COMMA_POS : COMMA_NEG}};
            do_reset();
            wait_link(1'b1);
            @(posedge clock);
            #1;
            cmp(link_notice, 1'b0, "notice too long");
        end
        $display("comma forms done");
    endtask

    task automatic t_error();
        int found = 0;
        far.got.delete();
        @(posedge clock);
        line_word[29:20] <= 10'h3ff;
        @(posedge clock);
        line_word <= {LANES{COMMA_POS}};
        repeat (12) @(posedge clock);
        foreach (far.got[i]) if (far.got[i][29:20] === ERROR_NEG) found++;
        cmp(found, 1, "error substitution");
        cmp(link_ok, 1'b1, "one bad kept sync");
        $display("error substitution done");
    endtask

    task automatic t_loop();
        logic [VEC_W-1:0] q[$];
        @(posedge clock);
        loopback <= 1'b1;
        wait_link(1'b0);
        wait_link(1'b1);
        far.got.delete();
        for (int i = 0; i < 3; i++) put(w[i]);
        far.release_tx();
        repeat (15) @(posedge clock);
        foreach (far.got[i]) if (far.got[i][9:0] === 10'h2aa || far.got[i][9:0] === 10'h0cc) q.push_back(far.got[i]);
        cmp(q.size(), 3, "looped word count");
        foreach (q[i]) cmp(q[i], w[i], "looped word");
        $display("loopback done");
    endtask

    task automatic t_overflow();
        int n = 0;
        stall <= 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 3; i++) put(w[i]);
        far.release_tx();
        while (rx_ovf !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        bound(n, 20);
        cmp(rx_valid, 1'b1, "full buffer holds");
        @(posedge clock);
        stall <= 1'b0;
        loopback <= 1'b0;
        wait_link(1'b0);
        wait_link(1'b1);
        $display("overflow done");
    endtask

    task automatic t_pattern();
        int n = 0;
        for (int s = 1; s < 4; s++) begin
            @(posedge clock);
            test_sel <= fpc_test_t'(s);
            repeat (3) @(posedge clock);
            #1;
            if (s == 3) cmp(tx_line === {LANES{COMMA_NEG}} || tx_line === {LANES{COMMA_POS}}, 1'b1, "mixed");
            else cmp(tx_line, {LANES{s == 1 ? PAT_HIGH : PAT_LOW}}, "pattern");
        end
        @(posedge clock);
        test_sel <= TEST_HIGH;
        put(w[0]);
        put(w[1]);
        #1;
        cmp(tx_ready, 1'b0, "tx full refuses");
        @(posedge clock);
        far.release_tx();
        test_sel <= TEST_OFF;
        while (tx_line !== w[0] && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        bound(n, 8);
        @(posedge clock);
        #1;
        cmp(tx_line, w[1], "tx order");
        repeat (3) @(posedge clock);
        put(w[2]);
        far.release_tx();
        @(posedge clock);
        #1;
        cmp(tx_line, w[2], "tx latency");
        $display("test patterns done");
    endtask

    task automatic t_prng();
        logic [6:0] first;
        int n = 0;
        #1;
        first = spacing;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (spacing !== first && n < 300);
        cmp(n, 127, "generator period");
        $display("generator done");
    endtask

    initial begin
        t_comma();
        t_error();
        t_loop();
        t_overflow();
        t_pattern();
        t_prng();
        give_verdict();
    end
endmodule
